/* File: src/serial_gauge_angle_decoder.sv */
// Overview of operation
// - ten-bit word; top three bits pick one of eight octants
// - low seven bits give step 0..127 inside the 45 degree octant
// - whole code is a linear angle, 1024 steps per circle
// - one coil full scale, the other follows tangent of octant offset
// - bits arrive and shift in most significant first
// - serial clock only acts while chip select is high
// - serial input sampled on rising serial clock edge
// - serial output changes on falling serial clock edge
// - serial output is always driven, never released
// - coils hold while shifting; chip select fall loads and updates
// - status low whenever coils disabled by enable or protection
// - chip select fall with the fault gone re-enables drivers disabled by a fault
// - reset clears shift register and latches
// - old word shifts out while new word shifts in
module serial_gauge_angle_decoder #(
  parameter int DRIVE_W = gauge_pkg::DRIVE_W
) (
  // core clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_reset,
  // serial link, clocked by the shift clock
  input  wire logic               i_sclk,
  input  wire logic               i_cs,
  input  wire logic               i_sdi,
  output logic                    o_sdo,
  // control and protection
  input  wire logic               i_output_enable,
  input  wire logic               i_fault,
  // coil drive, magnitude and sign (sign 1 = negative)
  output logic      [DRIVE_W-1:0] o_sine_coil_drive,
  output logic                    o_sine_neg,
  output logic      [DRIVE_W-1:0] o_cosine_coil_drive,
  output logic                    o_cosine_neg,
  output logic                    o_coils_enabled,
  output logic                    o_output_status_n
);
  localparam int W = gauge_pkg::WORD_W;

  // ---------------- link domain ----------------
  logic [W-1:0] shift_q;
  logic         sdo_q;
  logic [W-1:0] word_hold_q;   // captured on chip select fall
  logic         load_tgl_q;    // toggles once per update
  logic         cs_inactive;
  assign cs_inactive = ~i_cs;

  // shift msb first on rising sclk while selected
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      shift_q <= gauge_pkg::WORD_RESET;
    end else if (i_cs) begin
      shift_q <= {shift_q[W-2:0], i_sdi};
    end
  end

  // output changes on falling sclk; old msb leaves first
  always_ff @(negedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      sdo_q <= 1'b0;
    end else if (i_cs) begin
      sdo_q <= shift_q[W-1];
    end
  end

  assign o_sdo = sdo_q;

  // chip select fall latches the word; sclk may be idle then
  always_ff @(negedge i_cs or posedge i_reset) begin
    if (i_reset) begin
      word_hold_q <= gauge_pkg::WORD_RESET;
      load_tgl_q  <= 1'b0;
    end else begin
      word_hold_q <= shift_q;
      load_tgl_q  <= ~load_tgl_q;
    end
  end

  // ---------------- core domain ----------------
  // crossing scheme, link side to core side:
  //   the word is parked in word_hold_q at the chip select fall
  //   a single toggle bit announces that a new word is parked
  //   only the toggle and the unused cs level pass the two-flop synchroniser
  //   the parked word is read once the toggle edge is seen,
  //   by which time it has been still for at least two core cycles
  // trade-off: one update costs about four core cycles of latency,
  //   but no gray code or handshake back to the link is needed
  // limitation: two chip select falls closer than about three core
  //   cycles may merge into the later word, or into no update if the toggle flips back within one core cycle
  //
  // enable and fault are plain levels from pins:
  //   each passes two flops before any logic reads it
  //   a glitch shorter than one core cycle may be missed
  //
  // enable rule:
  //   the enable level is captured at each update
  //   the coils run only while captured and present levels are high
  //   so enable raised after the fall waits for the next update
  //
  // protection rule:
  //   a fault level latches the coils off
  //   only an update with the fault gone clears that latch
  //   a fault and an update in one cycle leave the latch set
  //
  // status output follows the coil enable, low while disabled
  logic       tgl_s1_q;
  logic       tgl_s2_q;
  logic       tgl_s3_q;
  logic       oe_s1_q;
  logic       oe_s2_q;
  logic       flt_s1_q;
  logic       flt_s2_q;
  logic       cs_s1_q;
  logic       cs_s2_q;
  logic [W-1:0] word_q;
  logic       oe_latch_q;
  logic       fault_off_q;
  logic       seen_load_q;

  // toggle and level synchronisers; first stage feeds only the second
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      oe_s1_q  <= 1'b0;
      oe_s2_q  <= 1'b0;
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
      cs_s1_q  <= 1'b0;
      cs_s2_q  <= 1'b0;
    end else begin
      tgl_s1_q <= load_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      oe_s1_q  <= i_output_enable;
      oe_s2_q  <= oe_s1_q;
      flt_s1_q <= i_fault;
      flt_s2_q <= flt_s1_q;
      cs_s1_q  <= cs_inactive;
      cs_s2_q  <= cs_s1_q;
    end
  end

  logic load_evt;
  assign load_evt = tgl_s2_q ^ tgl_s3_q;

  // word_hold_q is stable: it only changes at the cs fall behind the toggle
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      word_q      <= gauge_pkg::WORD_RESET;
      oe_latch_q  <= 1'b0;
      fault_off_q <= 1'b0;
      seen_load_q <= 1'b0;
    end else begin
      if (load_evt) begin
        word_q      <= word_hold_q;
        oe_latch_q  <= oe_s2_q;
        seen_load_q <= 1'b1;
      end
      // fault wins over the re-enable in the same cycle
      if (flt_s2_q) begin
        fault_off_q <= 1'b1;
      end else if (load_evt) begin
        fault_off_q <= 1'b0;
      end
    end
  end

  // decode octant and step
  logic [2:0] octant_select;
  logic [6:0] step;
  logic [6:0] step_eff;
  logic       octant_step_msb;
  logic [DRIVE_W-1:0] tan_val;
  assign octant_select   = word_q[gauge_pkg::OCT_MSB:gauge_pkg::OCT_LSB];
  assign step            = word_q[gauge_pkg::STEP_MSB:gauge_pkg::STEP_LSB];
  assign octant_step_msb = step[gauge_pkg::STEP_MSB];
  // odd octants count toward the next axis, so mirror the step
  assign step_eff        = octant_select[0] ? ~step : step;

  tangent_rom #(
    .STEPS   (gauge_pkg::STEPS),
    .DRIVE_W (DRIVE_W)
  ) u_tan (
    .i_step (step_eff),
    .o_tan  (tan_val)
  );

  // which coil is full scale: sine in octants 1,2,5,6
  logic sine_full;
  logic sine_neg_w;
  logic cos_neg_w;
  logic outputs_on;
  assign sine_full  = octant_select[0] ^ octant_select[1];
  assign sine_neg_w = octant_select[2];
  assign cos_neg_w  = octant_select[1] ^ octant_select[2];
  assign outputs_on = oe_latch_q & oe_s2_q & ~fault_off_q & seen_load_q;

  // registered coil drive; disabled coils read zero
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sine_coil_drive   <= '0;
      o_cosine_coil_drive <= '0;
      o_sine_neg          <= 1'b0;
      o_cosine_neg        <= 1'b0;
      o_coils_enabled     <= 1'b0;
      o_output_status_n   <= 1'b0;
    end else begin
      o_sine_coil_drive   <= outputs_on ? (sine_full ? gauge_pkg::FULL_SCALE : tan_val) : '0;
      o_cosine_coil_drive <= outputs_on ? (sine_full ? tan_val : gauge_pkg::FULL_SCALE) : '0;
      o_sine_neg          <= sine_neg_w;
      o_cosine_neg        <= cos_neg_w;
      o_coils_enabled     <= outputs_on;
      o_output_status_n   <= outputs_on;
    end
  end

  // cs level in core domain kept for future gating; unused bit avoided
  logic unused_ok;
  assign unused_ok = cs_s2_q & octant_step_msb;
endmodule : serial_gauge_angle_decoder

/* File: src/gauge_pkg.sv */
package gauge_pkg;
  // angle word layout
  localparam int WORD_W       = 10;
  localparam int OCT_W        = 3;
  localparam int STEP_W       = 7;
  localparam int OCT_MSB      = 9;
  localparam int OCT_LSB      = 7;
  localparam int STEP_MSB     = 6;
  localparam int STEP_LSB     = 0;
  // coil drive magnitude code width, full scale stands for 0.748 of supply
  localparam int DRIVE_W      = 12;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  localparam logic [9:0]  WORD_RESET = 10'h000;
  // tangent table step count per octant
  localparam int STEPS        = 128;
  // fixed point scale used to build the tangent table
  localparam real TAN_SCALE   = 4095.0;
  localparam real PI_VAL      = 3.14159265358979;
  localparam real OCT_RAD     = PI_VAL / 4.0;
endpackage : gauge_pkg

/* File: src/tangent_rom.sv */
// tangent of (step+0.5)/128 of one octant, scaled to full scale
module tangent_rom #(
  parameter int STEPS   = gauge_pkg::STEPS,
  parameter int DRIVE_W = gauge_pkg::DRIVE_W
) (
  // lookup
  input  wire logic [6:0]         i_step,
  output logic      [DRIVE_W-1:0] o_tan
);
  logic [DRIVE_W-1:0] table_q [STEPS];

  // constant table built at elaboration, no memory file
  function automatic logic [DRIVE_W-1:0] tan_entry(input int idx);
    real a;
    real t;
    a = (real'(idx) + 0.5) * gauge_pkg::OCT_RAD / real'(STEPS);
    t = $sin(a) / $cos(a);
    return DRIVE_W'(int'(t * gauge_pkg::TAN_SCALE));
  endfunction : tan_entry

  genvar g;
  generate
    for (g = 0; g < STEPS; g++) begin : g_tab
      assign table_q[g] = tan_entry(g);
    end
  endgenerate

  assign o_tan = table_q[i_step];
endmodule : tangent_rom

/* File: tb/serial_gauge_angle_decoder_asserts.sv */
module gauge_asserts #(
  parameter int DRIVE_W = 12
) (
  // clock, reset and controls
  input wire logic               i_core_clk,
  input wire logic               i_reset,
  input wire logic               i_cs,
  input wire logic               i_output_enable,
  input wire logic               i_fault,
  // coil side
  input wire logic [DRIVE_W-1:0] o_sine_coil_drive,
  input wire logic               o_sine_neg,
  input wire logic [DRIVE_W-1:0] o_cosine_coil_drive,
  input wire logic               o_cosine_neg,
  input wire logic               o_coils_enabled,
  input wire logic               o_output_status_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // cs held for six samples: any update from an earlier fall has landed
  sequence s_shift; i_cs [*6]; endsequence
  sequence s_idle; !i_cs [*8]; endsequence
  // enable held low long enough to pass the synchroniser and output flop
  property p_st; !i_output_enable [*4] |-> !o_output_status_n; endproperty
  property p_hold; s_shift |-> $stable({o_sine_coil_drive, o_cosine_coil_drive}); endproperty
  property p_full; o_coils_enabled |-> &o_sine_coil_drive || &o_cosine_coil_drive; endproperty
  property p_flt; i_fault |-> ##[1:5] !o_coils_enabled; endproperty
  property p_oe; !i_output_enable [*2] |-> ##[1:5] !o_coils_enabled; endproperty
  property p_on; s_idle |=> !$rose(o_coils_enabled); endproperty
  property p_upd; s_idle ##1 o_coils_enabled |-> $stable({o_sine_neg, o_cosine_neg,
    o_sine_coil_drive, o_cosine_coil_drive}); endproperty
  property p_rst; $fell(i_reset) |-> !o_coils_enabled && !o_output_status_n; endproperty
  a_st:   assert property (p_st) else $error("status high while off");
  a_hold: assert property (p_hold) else $error("coils moved while shifting");
  a_full: assert property (p_full) else $error("no full scale coil");
  a_flt:  assert property (p_flt) else $error("fault left coils on");
  a_oe:   assert property (p_oe) else $error("enable low left coils on");
  a_on:   assert property (p_on) else $error("enabled without cs fall");
  a_upd:  assert property (p_upd) else $error("update without cs fall");
  a_rst:  assert property (p_rst) else $error("outputs on after reset");
endmodule : gauge_asserts
bind serial_gauge_angle_decoder gauge_asserts #(.DRIVE_W(DRIVE_W)) u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cs(i_cs), .i_fault(i_fault),
  .i_output_enable(i_output_enable), .o_coils_enabled(o_coils_enabled),
  .o_sine_coil_drive(o_sine_coil_drive), .o_sine_neg(o_sine_neg),
  .o_cosine_coil_drive(o_cosine_coil_drive), .o_cosine_neg(o_cosine_neg),
  .o_output_status_n(o_output_status_n));

/* File: tb/gauge_mcu_model.sv */
module gauge_mcu_model (
  // serial port
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_cs,
  output logic      o_sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sclk = 1'b0;
    o_cs   = 1'b0;
    o_sdi  = 1'b0;
  end
  // one frame at a 12 ns shift clock; returns what the chain pushed out
  task automatic xfer(input logic [9:0] w, output logic [9:0] got);
    o_cs = 1'b1;
    for (int i = 9; i >= 0; i--) begin
      o_sdi = w[i];
      #6 o_sclk = 1'b1;
      got[i] = i_sdo;
      #6 o_sclk = 1'b0;
    end
    #6 o_cs = 1'b0;
    o_sdi = ~o_sdi; // released line must not keep the last bit
  endtask : xfer
  // edges with cs low, data toggling, to show they are ignored
  task automatic stray();
    repeat (3) begin
      o_sdi = ~o_sdi;
      #6 o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
    end
  endtask : stray
endmodule : gauge_mcu_model

/* File: tb/serial_gauge_angle_decoder_tb_top.sv */
module serial_gauge_angle_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // design inputs carry a value from time zero
  logic        i_core_clk      = 1'b0;
  logic        i_reset         = 1'b1;
  logic        i_output_enable = 1'b0;
  logic        i_fault         = 1'b0;
  logic        sclk, cs, sdi, sdo, sneg, cneg, en, st_n;
  logic [11:0] sdrv, cdrv;
  logic [9:0]  got;
  logic [9:0]  prev = 10'h000;
  logic [9:0]  codes[10] = '{10'h000, 10'h080, 10'h100, 10'h180, 10'h200,
                             10'h280, 10'h300, 10'h380, 10'h3ff, 10'h1ff};
  int          miscompares = 0;
  int          check_count = 0;
  always #5 i_core_clk = ~i_core_clk;
  serial_gauge_angle_decoder dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_sclk(sclk),
    .i_cs(cs), .i_sdi(sdi), .o_sdo(sdo), .i_output_enable(i_output_enable), .i_fault(i_fault),
    .o_sine_coil_drive(sdrv), .o_sine_neg(sneg), .o_cosine_coil_drive(cdrv),
    .o_cosine_neg(cneg), .o_coils_enabled(en), .o_output_status_n(st_n));
  gauge_mcu_model mcu (.i_sdo(sdo), .o_sclk(sclk), .o_cs(cs), .o_sdi(sdi));
  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // one frame, then the coil picture expected from the word once it lands
  task automatic send(input logic [9:0] w, input logic on);
    logic [2:0]  oct;
    logic [11:0] vm;
    oct = w[9:7];
    @(negedge i_core_clk);
    mcu.xfer(w, got);
    check(got === prev, "chained word");
    prev = w;
    repeat (8) @(negedge i_core_clk);
    vm = (oct[0] == oct[1]) ? sdrv : cdrv;
    check(en === on && st_n === on, "enable state");
    if (on) begin
      check(((oct[0] == oct[1]) ? cdrv : sdrv) === gauge_pkg::FULL_SCALE, "full");
      check((oct[0] == (w[6:0] < 7'h40)) ? vm > 12'hf80 && vm < 12'hfff : vm < 12'h020,
            "tangent coil");
      check(sneg === oct[2] && cneg === (oct[2] ^ oct[1]), "signs");
    end
  endtask : send
  initial begin
    repeat (5) @(negedge i_core_clk);
    i_reset = 1'b0;
    @(negedge i_core_clk);
    check(en === 1'b0 && st_n === 1'b0 && sdrv === 12'h000, "reset");
    i_output_enable = 1'b1;
    foreach (codes[i]) send(codes[i], 1'b1);
    $display("test octants done");
    mcu.stray();
    i_output_enable = 1'b0;
    send(10'h155, 1'b0);
    i_output_enable = 1'b1;
    send(10'h080, 1'b1);
    $display("test enable done");
    i_fault = 1'b1;
    repeat (8) @(negedge i_core_clk);
    send(10'h1ff, 1'b0);
    i_fault = 1'b0;
    repeat (8) @(negedge i_core_clk);
    check(en === 1'b0 && st_n === 1'b0, "fault latched");
    send(10'h3ff, 1'b1);
    $display("test fault done");
    give_verdict();
  end
  // run takes about 3.2 us, so 50 us can only be a hang
  initial begin
    #50us;
    miscompares++;
    give_verdict();
  end
endmodule : serial_gauge_angle_decoder_tb_top
